// *** design/sps_regs.svh ***
// Offsets, bit positions and reset values of the serial status block.
// Assumes inclusion by bare name from the design files.
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

`define SPS_STATUS_OFS 4'h0
`define SPS_CONTROL_OFS 4'h4
`define SPS_STATUS_RST 8'h84
`define SPS_CONTROL_RST 8'h00
`define SPS_TX_HOLD_FREE 7
`define SPS_RX_HOLD_FULL 6
`define SPS_OVERRUN_FLAG 5
`define SPS_STOP_FAULT 4
`define SPS_PARITY_FAULT 3
`define SPS_TX_DONE 2
`define SPS_RX_ADDR_FLAG_BIT 1
`define SPS_TX_ADDR_FLAG_BIT 0
`define SPS_FLAG_HI 7
`define SPS_FLAG_LO 3

`endif

// *** design/sps_pkg.sv ***
// Types shared by the serial status block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package sps_pkg;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [3:0] paddr;
		logic [31:0] pwdata;
	} sps_apb_s;

	// Control register, bit 7 down to bit 0
	typedef struct packed {
		logic odd_even_select;
		logic parity_en;
		logic mp_format;
		logic sync_mode;
		logic tx_done_irq_en;
		logic addr_wait_enable;
		logic rx_on;
		logic tx_on;
	} sps_ctrl_s;

	// End of a received character from the receive shifter
	typedef struct packed {
		logic done;
		logic stop_bit;
		logic parity_bit;
		logic data_parity;
		logic mp_bit;
	} sps_rx_ev_s;

	// Verdict on a received character
	typedef struct packed {
		logic load;
		logic overrun_flag;
		logic stop_fault;
		logic parity_fault;
		logic mpb_we;
		logic wait_clr;
	} sps_rx_res_s;

	// Whole state of the top module
	typedef struct packed {
		logic [7:0] stat;
		sps_ctrl_s ctrl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic tx_mp;
		logic rx_load;
		logic irq;
	} sps_top_s;

endpackage

// *** design/sps_arm.sv ***
// Per-flag arming for the read-then-write-zero clear sequence.
// Assumes the caller gives one-cycle read and write completion strobes.
module sps_arm #(
	parameter int W = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] set_ev,
	input wire logic rd_ok,
	input wire logic [W-1:0] rd_val,
	input wire logic wr_ok,
	input wire logic [W-1:0] wr_val,
	output logic [W-1:0] clr
);
	typedef struct packed {
		logic [W-1:0] arm;
	} sps_arm_s;

	sps_arm_s s;
	sps_arm_s next_s;

	// A zero written to an armed flag clears it
	assign clr = s.arm & ~wr_val & {W{wr_ok}};

	// A new set disarms, so a stale read cannot clear a fresh event
	always_comb begin
		next_s = s;
		next_s.arm = s.arm & ~set_ev & ~clr;
		if (rd_ok) begin
			next_s.arm = next_s.arm | (rd_val & ~set_ev);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // sps_arm

// *** design/sps_rx_eval.sv ***
// Judges one received character against mode and flag state.
// Assumes the receive shifter reports each character with a one-cycle done.
module sps_rx_eval (
	input wire sps_pkg::sps_ctrl_s ctrl,
	input wire sps_pkg::sps_rx_ev_s ev,
	input wire logic full,
	output sps_pkg::sps_rx_res_s res
);
	logic mp;
	logic take;

	// Address wait drops characters whose address bit is zero
	always_comb begin
		mp = ~ctrl.sync_mode & ctrl.mp_format;
		take = ev.done & ctrl.rx_on & ~(mp & ctrl.addr_wait_enable & ~ev.mp_bit);
		res.stop_fault = take & ~ctrl.sync_mode & ~ev.stop_bit;
		res.parity_fault = take & ~ctrl.sync_mode & ctrl.parity_en
			& ((ev.data_parity ^ ev.parity_bit) != ctrl.odd_even_select);
		res.overrun_flag = take & full;
		res.load = take & ~full & ~res.stop_fault & ~res.parity_fault;
		res.mpb_we = take & mp;
		res.wait_clr = take & mp & ctrl.addr_wait_enable;
	end
endmodule // sps_rx_eval

// *** design/sps_status.sv ***
// Status flags of the serial port behind an APB slave.
// Assumes shift engines give one-cycle pulses on mclk and APB is on mclk.
// How it works
// - Status is 8 bits, reset loads 84h
// - Software can never write flag bits to one
// - Clear needs a read of one first
// - Hold-to-shift move sets tx_hold_free
// - tx_on low sets tx_hold_free
// - Clean received character sets rx_hold_full
// - Character ending while full sets overrun_flag
// - Async stop bit zero sets stop_fault
// - Async parity mismatch sets parity_fault
// - Last bit with free hold sets tx_done
// - tx_done read-only, set by tx_on low
// - Async multiprocessor format captures received address bit
// - Received address bit otherwise kept unchanged
// - Transmit address bit double-buffered at move
// - Transmit address bit ignored outside multiprocessor
// - Address wait drops characters with bit zero
// - Irq only while tx_done and enabled
//
// The APB slave port and the register addresses were chosen for this implementation.
`include "sps_regs.svh"

module sps_status (
	input wire logic mclk,
	input wire logic rst,
	input wire logic standby,
	input wire sps_pkg::sps_apb_s apb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_load,
	input wire logic tx_char_end,
	input wire sps_pkg::sps_rx_ev_s rx_ev,
	output sps_pkg::sps_ctrl_s ctrl,
	output logic [7:0] status,
	output logic tx_halt,
	output logic tx_mp_bit,
	output logic rx_hold_load,
	output logic tx_done_irq
);
	sps_pkg::sps_top_s s;
	sps_pkg::sps_top_s next_s;
	sps_pkg::sps_rx_res_s rx_res;
	logic [4:0] set5;
	logic [4:0] clr5;
	logic done;
	logic hit_stat;
	logic hit_ctrl;
	logic rd_stat;
	logic wr_stat;
	logic wr_ctrl;
	logic set_tx_done;

	// Decide what a finished character does to the flags
	sps_rx_eval u_rx_eval (
		.ctrl(s.ctrl),
		.ev(rx_ev),
		.full(s.stat[`SPS_RX_HOLD_FULL]),
		.res(rx_res)
	);

	// Arming of the five clearable flags
	sps_arm #(
		.W(5)
	) u_arm (
		.mclk(mclk),
		.rst(rst),
		.set_ev(set5 | {5{standby}}),
		.rd_ok(rd_stat),
		.rd_val(s.prdata[`SPS_FLAG_HI:`SPS_FLAG_LO]),
		.wr_ok(wr_stat),
		.wr_val(apb.pwdata[`SPS_FLAG_HI:`SPS_FLAG_LO]),
		.clr(clr5)
	);

	// APB decode; pready rises one cycle after setup, so no wait states
	always_comb begin
		done = apb.psel & apb.penable & s.pready;
		hit_stat = apb.paddr == `SPS_STATUS_OFS;
		hit_ctrl = apb.paddr == `SPS_CONTROL_OFS;
		rd_stat = done & ~apb.pwrite & hit_stat;
		wr_stat = done & apb.pwrite & hit_stat;
		wr_ctrl = done & apb.pwrite & hit_ctrl;
	end

	// Hardware set events, flag bits 7 down to 3
	always_comb begin
		set5[4] = tx_load | ~s.ctrl.tx_on;
		set5[3] = rx_res.load;
		set5[2] = rx_res.overrun_flag;
		set5[1] = rx_res.stop_fault;
		set5[0] = rx_res.parity_fault;
		set_tx_done = ~s.ctrl.tx_on | (tx_char_end & s.stat[`SPS_TX_HOLD_FREE]);
	end

	// Next state of every register
	always_comb begin
		next_s = s;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.rx_load = rx_res.load;
		// Setup cycle: latch the answer so the access cycle sees a flop
		if (apb.psel & ~apb.penable) begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h0000_0000;
			if (hit_stat) begin
				next_s.prdata[7:0] = s.stat;
			end else if (hit_ctrl) begin
				next_s.prdata[7:0] = s.ctrl;
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		// Control writes; address wait drops once an address arrives
		if (wr_ctrl) begin
			next_s.ctrl = apb.pwdata[7:0];
		end else if (rx_res.wait_clr) begin
			next_s.ctrl.addr_wait_enable = 1'b0;
		end
		// Clear only armed bits, writes of one do nothing, sets win
		next_s.stat[`SPS_FLAG_HI:`SPS_FLAG_LO] =
			(s.stat[`SPS_FLAG_HI:`SPS_FLAG_LO] & ~clr5) | set5;
		// tx_done follows the tx_hold_free clear, not its own write
		if (set_tx_done) begin
			next_s.stat[`SPS_TX_DONE] = 1'b1;
		end else if (clr5[4]) begin
			next_s.stat[`SPS_TX_DONE] = 1'b0;
		end
		// Received address bit only in async multiprocessor format
		if (rx_res.mpb_we) begin
			next_s.stat[`SPS_RX_ADDR_FLAG_BIT] = rx_ev.mp_bit;
		end
		// Transmit address bit is plain read/write storage
		if (wr_stat) begin
			next_s.stat[`SPS_TX_ADDR_FLAG_BIT] = apb.pwdata[`SPS_TX_ADDR_FLAG_BIT];
		end
		// Second stage of the transmit address bit, taken with the data
		if (tx_load & ~s.ctrl.sync_mode & s.ctrl.mp_format) begin
			next_s.tx_mp = s.stat[`SPS_TX_ADDR_FLAG_BIT];
		end
		// Standby reinitialises the status just like reset
		if (standby) begin
			next_s.stat = `SPS_STATUS_RST;
		end
		next_s.irq = next_s.stat[`SPS_TX_DONE] & next_s.ctrl.tx_done_irq_en;
	end

	// Single state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
			s.stat <= `SPS_STATUS_RST;
			s.ctrl <= `SPS_CONTROL_RST;
		end else begin
			s <= next_s;
		end
	end

	// Outputs are all state bits
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign ctrl = s.ctrl;
	assign status = s.stat;
	assign tx_halt = s.stat[`SPS_TX_DONE];
	assign tx_mp_bit = s.tx_mp;
	assign rx_hold_load = s.rx_load;
	assign tx_done_irq = s.irq;

	// Checks on the flag behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_reset_value;
		$past(rst) |-> status == `SPS_STATUS_RST;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value");

	property p_no_write_one;
		(wr_stat && !status[`SPS_OVERRUN_FLAG] && !set5[2]) |=> !status[`SPS_OVERRUN_FLAG];
	endproperty
	a_no_write_one: assert property (p_no_write_one) else $error("flag written to one");

	// The clear sequence is checked in two steps, so no gap length has to be bounded
	property p_read_arms;
		(rd_stat && prdata[`SPS_RX_HOLD_FULL] && !set5[3] && !standby) |=> u_arm.s.arm[3];
	endproperty
	a_read_arms: assert property (p_read_arms) else $error("read did not arm");

	property p_armed_clear;
		(wr_stat && u_arm.s.arm[3] && !apb.pwdata[`SPS_RX_HOLD_FULL] && !set5[3] && !standby)
			|=> !status[`SPS_RX_HOLD_FULL];
	endproperty
	a_armed_clear: assert property (p_armed_clear) else $error("armed clear lost");

	property p_unarmed_keep;
		(wr_stat && status[`SPS_STOP_FAULT] && !u_arm.s.arm[1] && !standby)
			|=> status[`SPS_STOP_FAULT];
	endproperty
	a_unarmed_keep: assert property (p_unarmed_keep) else $error("unarmed clear");

	property p_move_sets_free;
		tx_load |=> status[`SPS_TX_HOLD_FREE];
	endproperty
	a_move_sets_free: assert property (p_move_sets_free) else $error("free not set");

	property p_tx_off;
		!ctrl.tx_on |=> status[`SPS_TX_HOLD_FREE] && status[`SPS_TX_DONE];
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("tx off flags");

	property p_overrun;
		(rx_ev.done && ctrl.rx_on && status[`SPS_RX_HOLD_FULL] && !ctrl.addr_wait_enable
			&& !standby && !clr5[3]) |=> status[`SPS_OVERRUN_FLAG] && status[`SPS_RX_HOLD_FULL];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_tx_end;
		(tx_char_end && status[`SPS_TX_HOLD_FREE]) |=> tx_halt;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("tx_done not set");

	// A move and an armed clear of tx_hold_free can meet; the move must survive
	property p_set_wins;
		(set5[4] && clr5[4] && !standby) |=> status[`SPS_TX_HOLD_FREE];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");

	property p_mpb_hold;
		(!ctrl.rx_on && !standby) |=> $stable(status[`SPS_RX_ADDR_FLAG_BIT]);
	endproperty
	a_mpb_hold: assert property (p_mpb_hold) else $error("mpb moved");

	property p_tx_mp_buf;
		(tx_load && !ctrl.sync_mode && ctrl.mp_format)
			|=> tx_mp_bit == $past(status[`SPS_TX_ADDR_FLAG_BIT]);
	endproperty
	a_tx_mp_buf: assert property (p_tx_mp_buf) else $error("mp bit not buffered");

	property p_irq;
		tx_done_irq == (status[`SPS_TX_DONE] && ctrl.tx_done_irq_en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_wait_drop;
		(rx_ev.done && ctrl.addr_wait_enable && ctrl.mp_format && !ctrl.sync_mode
			&& !rx_ev.mp_bit) |=> !rx_hold_load;
	endproperty
	a_wait_drop: assert property (p_wait_drop) else $error("waited char taken");

	property p_rx_clean;
		(rx_ev.done && ctrl.rx_on && !status[`SPS_RX_HOLD_FULL] && !ctrl.addr_wait_enable
			&& rx_ev.stop_bit && !ctrl.parity_en && !standby)
			|=> status[`SPS_RX_HOLD_FULL] && rx_hold_load;
	endproperty
	a_rx_clean: assert property (p_rx_clean) else $error("clean char not held");

	property p_stop_fault;
		(rx_ev.done && ctrl.rx_on && !ctrl.sync_mode && !rx_ev.stop_bit
			&& !ctrl.addr_wait_enable && !standby) |=> status[`SPS_STOP_FAULT];
	endproperty
	a_stop_fault: assert property (p_stop_fault) else $error("stop fault missed");

	property p_parity_fault;
		(rx_ev.done && ctrl.rx_on && !ctrl.sync_mode && ctrl.parity_en
			&& !ctrl.addr_wait_enable && !standby
			&& ((rx_ev.data_parity ^ rx_ev.parity_bit) != ctrl.odd_even_select))
			|=> status[`SPS_PARITY_FAULT];
	endproperty
	a_parity_fault: assert property (p_parity_fault) else $error("parity fault missed");

	property p_mpb_capture;
		(rx_ev.done && ctrl.rx_on && !ctrl.sync_mode && ctrl.mp_format && !standby
			&& !(ctrl.addr_wait_enable && !rx_ev.mp_bit))
			|=> status[`SPS_RX_ADDR_FLAG_BIT] == $past(rx_ev.mp_bit);
	endproperty
	a_mpb_capture: assert property (p_mpb_capture) else $error("mpb not captured");

	// Software can never move the received address bit
	property p_mpb_no_write;
		(wr_stat && !rx_ev.done && !standby) |=> $stable(status[`SPS_RX_ADDR_FLAG_BIT]);
	endproperty
	a_mpb_no_write: assert property (p_mpb_no_write) else $error("mpb written");

	property p_tx_done_clear;
		(clr5[4] && ctrl.tx_on && !tx_char_end && !standby) |=> !status[`SPS_TX_DONE];
	endproperty
	a_tx_done_clear: assert property (p_tx_done_clear) else $error("tx_done not cleared");

	property p_standby;
		standby |=> status == `SPS_STATUS_RST;
	endproperty
	a_standby: assert property (p_standby) else $error("standby value");

	c_overrun: cover property (rx_res.overrun_flag);
	c_tx_done_clear: cover property (clr5[4] && !set_tx_done);
	c_addr_seen: cover property (rx_res.wait_clr);
	c_bad_addr: cover property (pslverr);

endmodule // sps_status

// *** verification/sps_far_node.sv ***
// Behavioural far side: the shift engines that pulse the status block.
// Assumes the bench calls its tasks from one process, with mclk running.
module sps_far_node (
	input wire logic mclk,
	output logic tx_load,
	output logic tx_char_end,
	output sps_pkg::sps_rx_ev_s rx_ev
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle at time zero
	initial begin
		tx_load = 1'b0;
		tx_char_end = 1'b0;
		rx_ev = 5'h00;
	end

	// One character {stop, parity, data parity, mp}; fields are scrambled after
	// done so a design that samples them late sees wrong values
	task rx_char(input logic [3:0] f);
		@(posedge mclk);
		rx_ev <= {1'b1, f};
		@(posedge mclk);
		rx_ev <= {1'b0, ~f};
	endtask

	// One transmit engine pulse: hold-to-shift move, or last bit gone out
	task tx_pulse(input logic last);
		@(posedge mclk);
		tx_load <= ~last;
		tx_char_end <= last;
		@(posedge mclk);
		tx_load <= 1'b0;
		tx_char_end <= 1'b0;
	endtask
endmodule // sps_far_node

// *** verification/serial_port_status_flags_bench.sv ***
// Self-checking bench for the serial status block and its APB slave.
// Assumes the design files and the far-side model are compiled before it.
module serial_port_status_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic standby = 1'b0;
	sps_pkg::sps_apb_s bus = '0;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, rerr, tx_load, tx_char_end;
	logic tx_halt, tx_mp_bit, rx_hold_load, tx_done_irq;
	sps_pkg::sps_rx_ev_s rx_ev;
	sps_pkg::sps_ctrl_s ctrl;
	logic [7:0] status;
	int num_errors = 0;
	int num_checks = 0;

	// 200 MHz clock
	always #2.5 mclk = ~mclk;

	sps_status i_sps_status (.mclk(mclk), .rst(rst), .standby(standby), .apb(bus),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_load(tx_load),
		.tx_char_end(tx_char_end), .rx_ev(rx_ev), .ctrl(ctrl), .status(status),
		.tx_halt(tx_halt), .tx_mp_bit(tx_mp_bit), .rx_hold_load(rx_hold_load),
		.tx_done_irq(tx_done_irq));
	sps_far_node i_sps_far_node (.mclk(mclk), .tx_load(tx_load),
		.tx_char_end(tx_char_end), .rx_ev(rx_ev));

	// Verdict; also the exit of a hung handshake
	task conclude;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Outputs are looked at mid-cycle, after the edge's updates have landed
	task settle;
		@(negedge mclk);
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		bus <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk);
		bus.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			conclude();
		end
		rdata = prdata;
		rerr = pslverr;
		bus <= '0;
	endtask

	// Read then write zero: clears every flag that read as one, except one whose set event recurs up to the write edge
	task clr;
		xfer(1'b0, 4'h0, 32'h0);
		xfer(1'b1, 4'h0, 32'h0);
	endtask

	task t_reset;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		settle();
		chk(status, 32'h84);
		chk(ctrl, 32'h00);
		xfer(1'b0, 4'h0, 32'h0);
		chk(rdata, 32'h84);
		xfer(1'b0, 4'h8, 32'h0);
		chk(rerr, 32'h1);
		chk(rdata, 32'h0);
		// An unmapped write is refused and must leave control alone
		xfer(1'b1, 4'hC, 32'hFFFF_FFFF);
		chk(rerr, 32'h1);
		settle();
		chk(ctrl, 32'h00);
	endtask

	// Ones written to flags and read-only bits must not stick
	task t_write;
		xfer(1'b1, 4'h0, 32'hFF);
		settle();
		chk(status, 32'h85);
	endtask

	task t_transmit;
		xfer(1'b1, 4'h4, 32'h01);
		clr();
		settle();
		chk(status, 32'h00);
		i_sps_far_node.tx_pulse(1'b1);
		settle();
		chk(status, 32'h00);
		i_sps_far_node.tx_pulse(1'b0);
		settle();
		chk(status, 32'h80);
		// Armed clear and a hold-to-shift move at the same edge: the move wins
		xfer(1'b0, 4'h0, 32'h0);
		fork
			xfer(1'b1, 4'h0, 32'h0);
			begin
				@(posedge mclk);
				i_sps_far_node.tx_pulse(1'b0);
			end
		join
		settle();
		chk(status, 32'h80);
		xfer(1'b1, 4'h4, 32'h09);
		i_sps_far_node.tx_pulse(1'b1);
		settle();
		chk(status, 32'h84);
		chk(tx_halt, 32'h1);
		chk(tx_done_irq, 32'h1);
		clr();
		settle();
		chk(status, 32'h00);
		chk(tx_done_irq, 32'h0);
		xfer(1'b1, 4'h4, 32'h08);
		// tx_on drops at the write edge; the flags follow one edge later
		@(posedge mclk);
		settle();
		chk(status, 32'h84);
		chk(tx_done_irq, 32'h1);
	endtask

	task t_tx_addr;
		xfer(1'b1, 4'h0, 32'h01);
		xfer(1'b1, 4'h4, 32'h21);
		i_sps_far_node.tx_pulse(1'b0);
		settle();
		chk(tx_mp_bit, 32'h1);
		xfer(1'b1, 4'h0, 32'h00);
		settle();
		chk(tx_mp_bit, 32'h1);
		xfer(1'b1, 4'h4, 32'h31);
		i_sps_far_node.tx_pulse(1'b0);
		settle();
		chk(tx_mp_bit, 32'h1);
	endtask

	task t_receive;
		xfer(1'b1, 4'h4, 32'h02);
		i_sps_far_node.rx_char(4'h8);
		settle();
		chk(status & 8'h7A, 32'h40);
		chk(rx_hold_load, 32'h1);
		xfer(1'b1, 4'h0, 32'h0);
		settle();
		chk(status & 8'h7A, 32'h40);
		i_sps_far_node.rx_char(4'h8);
		settle();
		chk(status & 8'h7A, 32'h60);
		chk(rx_hold_load, 32'h0);
		clr();
		settle();
		chk(status & 8'h7A, 32'h00);
		i_sps_far_node.rx_char(4'h0);
		settle();
		chk(status & 8'h7A, 32'h10);
		xfer(1'b1, 4'h4, 32'hC2);
		i_sps_far_node.rx_char(4'h8);
		settle();
		chk(status & 8'h7A, 32'h18);
	endtask

	task t_mp;
		clr();
		xfer(1'b1, 4'h4, 32'hFFFF_FF22);
		i_sps_far_node.rx_char(4'h9);
		settle();
		chk(status[1], 32'h1);
		xfer(1'b1, 4'h4, 32'h32);
		i_sps_far_node.rx_char(4'h8);
		settle();
		chk(status[1], 32'h1);
		clr();
		xfer(1'b1, 4'h4, 32'h22);
		i_sps_far_node.rx_char(4'h8);
		settle();
		chk(status[1], 32'h0);
		clr();
		xfer(1'b1, 4'h4, 32'h26);
		i_sps_far_node.rx_char(4'h8);
		settle();
		chk(status & 8'h7A, 32'h00);
		chk(rx_hold_load, 32'h0);
		i_sps_far_node.rx_char(4'h9);
		settle();
		chk(status & 8'h7A, 32'h42);
		chk(ctrl.addr_wait_enable, 32'h0);
	endtask

	// Standby reloads status but keeps control
	task t_standby;
		@(posedge mclk);
		standby <= 1'b1;
		@(posedge mclk);
		standby <= 1'b0;
		settle();
		chk(status, 32'h84);
		chk(ctrl, 32'h22);
		// Upper data bits were ignored on write and read back as zero
		xfer(1'b0, 4'h4, 32'h0);
		chk(rdata, 32'h22);
	endtask

	// Main sequence
	initial begin
		t_reset();
		t_write();
		t_transmit();
		t_tx_addr();
		t_receive();
		t_mp();
		t_standby();
		conclude();
	end
endmodule // serial_port_status_flags_bench
